// ---- include/adc_link_pkg.sv ----
// Purpose: Shared constants for the serial converter link and its host
// Assumes: pclk at 25 MHz on both ends
// Notes:   Configuration byte layout and host register map
package adc_link_pkg;
  localparam int unsigned   CFG_W          = 8;
  localparam int unsigned   RES_W          = 18;
  localparam int unsigned   MODE_HI        = 7;
  localparam int unsigned   MODE_LO        = 6;
  localparam int unsigned   REF_HI         = 5;
  localparam int unsigned   REF_LO         = 4;
  localparam int unsigned   PD_POS         = 3;
  localparam logic [7:0]    CFG_RESET      = 8'h00;
  localparam logic [7:0]    CFG_USED_MASK  = 8'hf8;
  localparam logic [17:0]   MIDSCALE       = 18'h20000;
  localparam logic [4:0]    CFG_BITS       = 5'h08;
  localparam logic [4:0]    RES_BITS       = 5'h12;
  localparam logic [4:0]    RES_BITS_BUSY  = 5'h13;
  localparam int unsigned   CLK_NS         = 40;
  localparam int unsigned   QUIET_BEFORE_NS = 25;
  localparam int unsigned   QUIET_AFTER_NS = 10;
  localparam int unsigned   QUIET_BEFORE_CYC =
    (QUIET_BEFORE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned   QUIET_AFTER_CYC =
    (QUIET_AFTER_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0]    OFS_CTRL       = 4'h0;
  localparam logic [3:0]    OFS_CFG        = 4'h4;
  localparam logic [3:0]    OFS_STATUS     = 4'h8;
  localparam logic [3:0]    OFS_DATA       = 4'hc;
  typedef enum logic [1:0] {
    MODE_SEL      = 2'b00,
    MODE_SEL_BUSY = 2'b01,
    MODE_DC       = 2'b10,
    MODE_DC_BUSY  = 2'b11
  } out_mode_t;
endpackage : adc_link_pkg

// ---- include/adc_link_if.sv ----
// Purpose: Serial pins between converter and host
// Assumes: Output line pulled high when nobody drives it
// Notes:   Host drives clock, select and serial input
`timescale 1ns/1ps
interface adc_link_if;
  logic sclk;
  logic convert_start_select;
  logic din;
  logic dout;
  logic dout_oe;
  logic dout_line;
  // External pullup holds the line high when released
  assign dout_line = dout_oe ? dout : 1'b1;
  modport device_end (
    input  sclk, convert_start_select, din,
    output dout, dout_oe
  );
  modport host_end (
    output sclk, convert_start_select, din,
    input  dout_line
  );
endinterface : adc_link_if

// ---- src/adc_serial_device.sv ----
// Purpose: Digital serial end of an 18-bit converter
// Assumes: Link pins asynchronous to pclk, sclk well below pclk/6
// Notes:   Conversion timed by a cycle count; code from sample_value
// Contract
// - Result is 18-bit offset binary code
// - Config bits captured on falling clock edges
// - Select fall with clock high starts load
// - Select modes shift eight bits, rise completes
// - Host idles serial input high
// - Bits 7:6 choose output interface mode
// - Bits 5:4 choose reference and buffer
// - Power-down bit shuts down, resets registers
// - Daisy modes chain config as FIFO
// - New config applies from next conversion
// - No-busy host waits maximum conversion time
// - Busy host may use output as interrupt
// - Host quiet around rising select edge
// - Output stable both edges; host samples falling
// - Host idles serial clock low
// - Unread leftover bits come out next readout
// - Select rise converts, output released
// - Select low through conversion gives MSB
// - Select low shows MSB, falls shift rest
// - Released after 18th fall or select rise
// - Busy mode drives low, 19 falls
// - Daisy shows own MSB, passes upstream data
`timescale 1ns/1ps
module adc_serial_device
  import adc_link_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = 40
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  adc_link_if.device_end         link,
  input  wire logic [17:0]       sample_value,
  output logic [1:0]             mode,
  output logic                   ref_on,
  output logic                   buf_on,
  output logic                   powered_down,
  output logic                   converting
);
  localparam logic [15:0] CONV_LAST = 16'(CONV_CYCLES - 1);

  logic [2:0]  sclk_q;
  logic [2:0]  sel_q;
  logic [1:0]  din_q;
  logic        cfg_act_q;
  logic [4:0]  cfg_cnt_q;
  logic [7:0]  cfg_sh_q;
  logic [7:0]  pend_q;
  logic        pend_new_q;
  logic [7:0]  cfg_q;
  logic        pd_q;
  logic        conv_q;
  logic [15:0] conv_cnt_q;
  logic [17:0] code_q;
  logic [17:0] sh_q;
  logic [4:0]  left_q;
  logic        busy_ph_q;
  logic        dout_q;
  logic        oe_q;
  logic        ref_on_q;
  logic        buf_on_q;

  // Synchronised pins; stage 0 feeds only stage 1
  wire sclk_s    = sclk_q[1];
  wire sel_s     = sel_q[1];
  wire din_s     = din_q[1];
  wire sclk_fall = sclk_q[2] & ~sclk_s;
  wire sel_fall  = sel_q[2] & ~sel_s;
  wire sel_rise  = ~sel_q[2] & sel_s;

  wire daisy     = cfg_q[MODE_HI];
  wire busy_mode = cfg_q[MODE_LO];
  wire load_go   = sel_fall & sclk_s & ~conv_q;
  wire cfg_done  = cfg_cnt_q >= CFG_BITS;
  wire cfg_shift = cfg_act_q & sclk_fall & (daisy | ~cfg_done);
  wire cfg_commit = cfg_act_q & sel_rise & (daisy | cfg_done);
  wire conv_go   = sel_rise & ~pd_q;
  wire conv_end  = conv_q & (conv_cnt_q == 16'h0000);
  wire rd_fall   = sclk_fall & ~sel_s & ~cfg_act_q & ~conv_q;
  wire have_bits = left_q != 5'h00;
  wire drive_sel = ~sel_s & (busy_ph_q | have_bits);
  wire drive_d   = daisy | cfg_act_q ? 1'b1 : drive_sel;
  wire drive_nxt = ~conv_q & ~conv_go & drive_d;
  wire dout_nxt  = cfg_act_q ? cfg_sh_q[7] :
                   (busy_ph_q ? 1'b0 : sh_q[17]);
  // Flip the sign bit: signed input to offset binary
  wire [17:0] offset_code = sample_value ^ MIDSCALE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q <= 3'h0;
      sel_q  <= 3'h7;
      din_q  <= 2'h3;
    end else begin
      sclk_q <= {sclk_q[1:0], link.sclk};
      sel_q  <= {sel_q[1:0], link.convert_start_select};
      din_q  <= {din_q[0], link.din};
    end
  end

  // Configuration load path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_act_q <= 1'b0;
      cfg_cnt_q <= 5'h00;
      cfg_sh_q  <= CFG_RESET;
    end else if (load_go) begin
      cfg_act_q <= 1'b1;
      cfg_cnt_q <= 5'h00;
    end else if (sel_rise) begin
      cfg_act_q <= 1'b0;
    end else if (cfg_shift) begin
      cfg_sh_q  <= {cfg_sh_q[6:0], din_s};
      if (!cfg_done)
        cfg_cnt_q <= cfg_cnt_q + 5'h01;
    end
  end

  // Pending byte waits for the next conversion start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q     <= CFG_RESET;
      pend_new_q <= 1'b0;
      cfg_q      <= CFG_RESET;
      pd_q       <= 1'b0;
    end else if (cfg_commit && cfg_sh_q[PD_POS]) begin
      // Static shutdown wipes all settings at once
      pend_q     <= CFG_RESET;
      pend_new_q <= 1'b0;
      cfg_q      <= CFG_RESET;
      pd_q       <= 1'b1;
    end else if (cfg_commit) begin
      pend_q     <= cfg_sh_q;
      pend_new_q <= 1'b1;
      pd_q       <= 1'b0;
    end else if (conv_go && pend_new_q) begin
      cfg_q      <= pend_q;
      pend_new_q <= 1'b0;
    end
  end

  // Conversion timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_q     <= 1'b0;
      conv_cnt_q <= 16'h0000;
      code_q     <= MIDSCALE;
    end else if (conv_go && !conv_q) begin
      conv_q     <= 1'b1;
      conv_cnt_q <= CONV_LAST;
      code_q     <= offset_code;
    end else if (conv_end) begin
      conv_q     <= 1'b0;
    end else if (conv_q) begin
      conv_cnt_q <= conv_cnt_q - 16'h0001;
    end
  end

  // Result shifter; a new word only lands once the old is drained
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q      <= 18'h00000;
      left_q    <= 5'h00;
      busy_ph_q <= 1'b0;
    end else if (cfg_commit && cfg_sh_q[PD_POS]) begin
      sh_q      <= 18'h00000;
      left_q    <= 5'h00;
      busy_ph_q <= 1'b0;
    end else if (conv_end && !have_bits) begin
      sh_q      <= code_q;
      left_q    <= RES_BITS;
      busy_ph_q <= busy_mode;
    end else if (rd_fall && busy_ph_q) begin
      busy_ph_q <= 1'b0;
    end else if (rd_fall && (have_bits || daisy)) begin
      sh_q      <= {sh_q[16:0], din_s};
      if (have_bits)
        left_q  <= left_q - 5'h01;
    end
  end

  // Pins and status out of flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_q   <= 1'b1;
      oe_q     <= 1'b0;
      ref_on_q <= 1'b1;
      buf_on_q <= 1'b1;
    end else begin
      dout_q   <= dout_nxt;
      oe_q     <= drive_nxt & ~pd_q;
      ref_on_q <= ~cfg_q[REF_LO] & ~pd_q;
      buf_on_q <= ~cfg_q[REF_HI] & ~pd_q;
    end
  end

  assign link.dout    = dout_q;
  assign link.dout_oe = oe_q;
  assign mode         = cfg_q[MODE_HI:MODE_LO];
  assign ref_on       = ref_on_q;
  assign buf_on       = buf_on_q;
  assign powered_down = pd_q;
  assign converting   = conv_q;
endmodule : adc_serial_device

// ---- src/adc_serial_host.sv ----
// Purpose: APB-driven host that configures and reads the converter
// Assumes: One converter on the link
// Notes:   Link clock made by dividing pclk
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
module adc_serial_host
  import adc_link_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = 4,
  parameter int unsigned WAIT_CYCLES = 48
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  adc_link_if.host_end           link
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CFG_A = 3'b001,
    ST_CFG_B = 3'b010,
    ST_CFG_C = 3'b011,
    ST_CONV  = 3'b100,
    ST_BUSY  = 3'b101,
    ST_READ  = 3'b110
  } host_st_t;

  localparam logic [7:0]  HALF_LAST = 8'(HALF_CYCLES - 1);
  localparam logic [15:0] WAIT_LAST = 16'(WAIT_CYCLES - 1);
  localparam logic [15:0] QA_LAST   = 16'(QUIET_AFTER_CYC - 1);
  // Old drive on the line needs the sync depth to clear before busy is trusted
  localparam logic [15:0] BUSY_LAST = 16'(QUIET_AFTER_CYC + 4);

  host_st_t    st_q;
  logic [7:0]  div_q;
  logic [15:0] wait_q;
  logic        sclk_q, sel_q, din_q;
  logic [7:0]  cfg_reg_q, tx_q;
  logic [4:0]  bit_q;
  logic [17:0] rx_q, data_q;
  logic        valid_q;
  logic [1:0]  dout_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        busy_act_q;
  logic        busy_pend_q;
  logic        pend_new_q;
  logic        cfg_path_q;

  wire dout_s   = dout_q[1];
  wire tick     = div_q == HALF_LAST;
  // Mirror of the mode the converter really uses: a loaded byte waits a conversion
  wire busy_sel = busy_act_q;
  wire busy_next = cfg_path_q ? busy_act_q & ~cfg_reg_q[PD_POS] :
                   (pend_new_q ? busy_pend_q : busy_act_q);
  wire [4:0] n_bits = busy_sel ? RES_BITS_BUSY : RES_BITS;
  wire acc      = psel & penable;
  wire wr       = acc & pwrite;
  wire [3:0] ofs = paddr[3:0];
  wire mapped   = paddr[31:4] == 28'h0 && ofs[1:0] == 2'b00;
  wire go_cfg   = wr & mapped & ofs == OFS_CTRL & pwdata[0] & st_q == ST_IDLE;
  wire go_conv  = wr & mapped & ofs == OFS_CTRL & pwdata[1] & st_q == ST_IDLE;
  wire idle_f   = st_q == ST_IDLE;
  wire [31:0] rd_mux =
    ofs == OFS_CFG    ? {24'h0, cfg_reg_q} :
    ofs == OFS_STATUS ? {30'h0, valid_q, ~idle_f} :
    ofs == OFS_DATA   ? {14'h0, data_q} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
      cfg_reg_q <= CFG_RESET;
      dout_q    <= 2'h3;
    end else begin
      dout_q    <= {dout_q[0], link.dout_line};
      pslverr_q <= psel & ~mapped;
      prdata_q  <= mapped ? rd_mux : 32'h0;
      if (wr && mapped && ofs == OFS_CFG)
        cfg_reg_q <= pwdata[7:0] & CFG_USED_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= ST_IDLE;
      div_q   <= 8'h00;
      wait_q  <= 16'h0000;
      sclk_q  <= 1'b0;
      sel_q   <= 1'b1;
      din_q   <= 1'b1;
      tx_q    <= CFG_RESET;
      bit_q   <= 5'h00;
      rx_q    <= 18'h00000;
      data_q  <= 18'h00000;
      valid_q <= 1'b0;
      busy_act_q  <= 1'b0;
      busy_pend_q <= 1'b0;
      pend_new_q  <= 1'b0;
      cfg_path_q  <= 1'b0;
    end else begin
      div_q <= tick || idle_f ? 8'h00 : div_q + 8'h01;
      case (st_q)
        ST_IDLE: begin
          sclk_q <= 1'b0;
          din_q  <= 1'b1;
          if (go_cfg) begin
            sclk_q <= 1'b1;
            tx_q   <= cfg_reg_q;
            cfg_path_q <= 1'b1;
            st_q   <= ST_CFG_A;
          end else if (go_conv) begin
            sel_q  <= 1'b0;
            cfg_path_q <= 1'b0;
            st_q   <= ST_CFG_C;
          end
        end
        ST_CFG_A: if (tick) begin
          sel_q <= 1'b0;
          din_q <= tx_q[7];
          bit_q <= 5'h00;
          st_q  <= ST_CFG_B;
        end
        ST_CFG_B: if (tick && sclk_q) begin
          sclk_q <= 1'b0;
          tx_q   <= {tx_q[6:0], 1'b0};
          bit_q  <= bit_q + 5'h01;
        end else if (tick && bit_q == CFG_BITS) begin
          din_q  <= 1'b1;
          st_q   <= ST_CFG_C;
        end else if (tick) begin
          sclk_q <= 1'b1;
          din_q  <= tx_q[7];
        end
        ST_CFG_C: if (tick) begin
          // Inputs already still for a half period: quiet before
          sel_q  <= 1'b1;
          wait_q <= busy_next ? BUSY_LAST : WAIT_LAST;
          busy_act_q  <= busy_next;
          pend_new_q  <= cfg_path_q & ~cfg_reg_q[PD_POS];
          busy_pend_q <= cfg_reg_q[MODE_LO];
          st_q   <= ST_CONV;
        end
        ST_CONV: if (wait_q != 16'h0000) begin
          wait_q <= wait_q - 16'h0001;
        end else begin
          sel_q  <= 1'b0;
          bit_q  <= 5'h00;
          st_q   <= busy_sel ? ST_BUSY : ST_READ;
        end
        ST_BUSY: if (!dout_s)
          st_q <= ST_READ;
        ST_READ: if (tick && sclk_q) begin
          sclk_q <= 1'b0;
          rx_q   <= {rx_q[16:0], dout_s};
          bit_q  <= bit_q + 5'h01;
        end else if (tick && bit_q == n_bits) begin
          data_q  <= rx_q;
          valid_q <= 1'b1;
          sel_q   <= 1'b1;
          st_q    <= ST_IDLE;
          pend_new_q <= 1'b0;
          if (pend_new_q)
            busy_act_q <= busy_pend_q;
        end else if (tick) begin
          sclk_q <= 1'b1;
        end
        default: st_q <= ST_IDLE;
      endcase
      if (go_cfg || go_conv)
        valid_q <= 1'b0;
    end
  end

  assign prdata      = prdata_q;
  assign pready      = 1'b1;
  assign pslverr     = pslverr_q;
  assign link.sclk   = sclk_q;
  assign link.convert_start_select = sel_q;
  assign link.din    = din_q;
endmodule : adc_serial_host

// ---- testbench/adc_link_asserts.sv ----
// Purpose: Checks on the serial wires between host and converter
// Assumes: Host half period of 4 pclk
// Notes:   Sees only interface signals
`timescale 1ns/1ps
module adc_link_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic convert_start_select,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic dout_line
);
  logic       sel_q;
  logic       sclk_q;
  logic       cfg_on_q;
  logic [4:0] falls_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Counts clock falls within a configuration frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q    <= 1'b1;
      sclk_q   <= 1'b0;
      cfg_on_q <= 1'b0;
      falls_q  <= 5'h00;
    end else begin
      sel_q  <= convert_start_select;
      sclk_q <= sclk;
      if (sel_q && !convert_start_select && sclk) begin
        cfg_on_q <= 1'b1;
        falls_q  <= 5'h00;
      end else if (convert_start_select) begin
        cfg_on_q <= 1'b0;
      end else if (cfg_on_q && sclk_q && !sclk) begin
        falls_q <= falls_q + 5'h01;
      end
    end
  end
  sequence quiet_s;
    $stable(sclk) && $stable(din);
  endsequence
  a_conv_release: assert property ($rose(convert_start_select) |-> ##[1:5] !dout_oe)
    else $error("output still driven after convert start");
  a_cfg_eight: assert property ($rose(convert_start_select) && cfg_on_q |-> falls_q == 5'h08)
    else $error("config frame not eight clock falls");
  a_cfg_din: assert property (cfg_on_q && $fell(sclk) |-> $stable(din))
    else $error("serial input moved at capturing fall");
  a_din_idle: assert property (convert_start_select [*6] |-> din)
    else $error("serial input not idle high");
  a_quiet_edge: assert property ($rose(convert_start_select) |-> quiet_s ##1 quiet_s)
    else $error("clock or input moved near convert start");
  a_sclk_idle: assert property ($rose(convert_start_select) |-> !sclk)
    else $error("serial clock not idle low");
  a_dout_steady: assert property (sclk && $past(sclk) && dout_oe && $past(dout_oe)
    |-> $stable(dout_line))
    else $error("output changed while clock high");
  a_sclk_half: assert property ($rose(sclk) && !convert_start_select
    && !$fell(convert_start_select) |-> sclk [*4] ##1 !sclk)
    else $error("serial clock high phase wrong length");
endmodule : adc_link_asserts

// ---- testbench/tb_top.sv ----
// Purpose: Self-checking run of host and converter over APB
// Assumes: Short conversion and wait counts
// Notes:   Each sample converted twice, then data read once; it holds the new sample
`timescale 1ns/1ps
module tb_top;
  import adc_link_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [17:0] sample_value;
  logic [1:0]  mode;
  logic        ref_on, buf_on, powered_down, converting;
  int          n_mismatch, n_tests;
  adc_link_if link_bus ();
  adc_serial_host #(.HALF_CYCLES(4), .WAIT_CYCLES(12)) adc_serial_host_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link_bus));
  adc_serial_device #(.CONV_CYCLES(8)) adc_serial_device_i (
    .pclk(pclk), .presetn(presetn), .link(link_bus), .sample_value(sample_value),
    .mode(mode), .ref_on(ref_on), .buf_on(buf_on), .powered_down(powered_down),
    .converting(converting));
  adc_link_asserts adc_link_asserts_i (
    .pclk(pclk), .presetn(presetn), .sclk(link_bus.sclk),
    .convert_start_select(link_bus.convert_start_select), .din(link_bus.din),
    .dout(link_bus.dout), .dout_oe(link_bus.dout_oe), .dout_line(link_bus.dout_line));
  always #20 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {28'h0, a};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic idle_wait();
    int k;
    k = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      k++;
    end while (rd[0] !== 1'b0 && k < 3000);
    chk({31'h0, rd[0]}, 32'h0);
  endtask : idle_wait
  task automatic go(input logic [31:0] c);
    apb(1'b1, OFS_CTRL, c);
    idle_wait();
  endtask : go
  task automatic conv2(input logic [17:0] s);
    sample_value <= s;
    go(32'h2);
    go(32'h2);
    chk({31'h0, rd[1]}, 32'h1);
    apb(1'b0, OFS_DATA, 32'h0);
    chk(rd, {14'h0, s ^ MIDSCALE});
  endtask : conv2
  task automatic load(input logic [7:0] c, input logic [7:0] p);
    apb(1'b1, OFS_CFG, {24'h0, c});
    apb(1'b0, OFS_CFG, 32'h0);
    chk(rd, {24'h0, c & CFG_USED_MASK});
    apb(1'b1, OFS_CTRL, 32'h1);
    // Just past the commit edge the old mode must still be in force
    @(posedge link_bus.convert_start_select);
    repeat (4) @(posedge pclk);
    chk({30'h0, mode}, {30'h0, p[7:6]});
    idle_wait();
  endtask : load
  task automatic t_reset();
    chk({26'h0, converting, powered_down, mode, ref_on, buf_on}, 32'h3);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    // Unmapped word is refused with no data
    apb(1'b0, 4'h0, 32'h0);
    apb(1'b1, 4'h0, 32'h0);
    @(posedge pclk);
    paddr <= 32'h10;
    psel  <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    chk({31'h0, pslverr}, 32'h1);
    chk(prdata, 32'h0);
    psel    <= 1'b0;
    penable <= 1'b0;
    $display("t_reset done");
  endtask : t_reset
  task automatic t_values();
    logic [17:0] s [4] = '{18'h00000, 18'h20000, 18'h1ffff, 18'h3ffff};
    for (int i = 0; i < 4; i++) begin
      conv2(s[i]);
    end
    $display("t_values done");
  endtask : t_values
  task automatic t_modes();
    logic [7:0] c [4] = '{8'h57, 8'ha0, 8'hf0, 8'h00};
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 4; i++) begin
      load(c[i], p);
      conv2(18'h0ab3c);
      chk({30'h0, mode}, {30'h0, c[i][7:6]});
      chk({30'h0, ref_on, buf_on}, {30'h0, ~c[i][4], ~c[i][5]});
      p = c[i];
    end
    $display("t_modes done");
  endtask : t_modes
  task automatic t_shutdown();
    load(8'h38, 8'h00);
    chk({27'h0, powered_down, mode, ref_on, buf_on}, 32'h10);
    load(8'h00, 8'h00);
    conv2(18'h12345);
    chk({27'h0, powered_down, mode, ref_on, buf_on}, 32'h3);
    $display("t_shutdown done");
  endtask : t_shutdown
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    sample_value = 18'h00000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_values();
    t_modes();
    t_shutdown();
    report_and_stop();
  end
  // Far beyond the expected run length of a few thousand cycles
  initial begin
    repeat (60000) @(posedge pclk);
    n_mismatch++;
    report_and_stop();
  end
endmodule : tb_top
